// >>> verilog/flash_pkg.sv
package flash_pkg;

    // ------------------------------------------------------------
    // Address map, CPU side (byte addresses of the CPU space)
    // ------------------------------------------------------------
    localparam int APB_AW = 18;                   // Byte address = 4 * CPU
    localparam int ARR_AW = 14;                   // Index into the array
    localparam int DEPTH = 16384;                 // Cells in the array
    localparam logic [15:0] ARRAY_BASE = 16'hc000;
    localparam logic [15:0] CTRL_ADDR = 16'hfe08;
    localparam logic [15:0] STATUS_ADDR = 16'hfe09;
    localparam logic [15:0] PROTECT_ADDR = 16'hff7e;
    localparam logic [11:0] HOLE_PREFIX = 12'hfe0; // Register hole

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PAGE_LSB = 6;                  // 64-byte page
    localparam int ROW_LSB = 5;                   // 32-byte row
    localparam logic [5:0] PAGE_LAST = 6'h3f;
    localparam logic [ARR_AW-1:0] ARR_LAST = 14'h3fff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [1:0] PROT_TOP = 2'b11;      // Start bits 15:14

    // ------------------------------------------------------------
    // Control and status bit positions
    // ------------------------------------------------------------
    localparam int HV_BIT = 3;
    localparam int BULK_BIT = 2;
    localparam int ERASE_BIT = 1;
    localparam int PROG_BIT = 0;
    localparam int ST_WIPING = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_HV = 2;
    localparam int ST_LATCHED = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int NVS_US = 10;                   // Select to HV setup
    localparam logic [7:0] NVS_CYC = 8'(NVS_US * CLK_MHZ);

    // Sequence tracker states
    typedef enum logic [2:0] {
        S_IDLE, S_SELECTED, S_PROT_READ, S_LATCHED, S_HV_ON
    } seq_t;

endpackage

// >>> verilog/flash_array_if.sv
`timescale 1ns/10ps
// Control side to cell array: write strobes, read port, protect byte
interface flash_array_if #(parameter int AW = 14);
    logic prog_we;          // Program: cell takes old AND data
    logic wipe_we;          // Erase one cell to all ones
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic [AW-1:0] raddr;
    logic [7:0] rdata;
    logic [7:0] protect_byte;
    modport ctrl(output prog_we, wipe_we, waddr, wdata, raddr,
                 input rdata, protect_byte);
    modport cells(input prog_we, wipe_we, waddr, wdata, raddr,
                  output rdata, protect_byte);
endinterface

// >>> verilog/flash_protect_check.sv
`timescale 1ns/10ps
// Decodes the protect byte into a start address and tests a target
module flash_protect_check (
    input wire logic [7:0] protect_start_bits,
    input wire logic [13:0] target,
    output logic hit,
    output logic bulk_ok
);
    logic [15:0] start;
    logic [15:0] full;

    // Start = 11, bits, six zeros; protection runs to the top
    always_comb begin
        start = {flash_pkg::PROT_TOP, protect_start_bits, 6'h00};
        full = {flash_pkg::PROT_TOP, target};
        // All ones means nothing is protected at all
        hit = (protect_start_bits != flash_pkg::ERASED_BYTE) &&
              (full >= start);                   // see [RULE24]
        bulk_ok = (protect_start_bits == flash_pkg::ERASED_BYTE);
    end
endmodule

// >>> verilog/flash_cell_array.sv
`timescale 1ns/10ps
// Byte-wide nonvolatile cells; programming can only clear bits
module flash_cell_array #(parameter int DEPTH = flash_pkg::DEPTH) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    flash_array_if.cells arr
);
    localparam logic [13:0] PROT_IDX = flash_pkg::PROTECT_ADDR[13:0];

    logic [7:0] mem [DEPTH];   // Cell storage, not touched by reset
    logic [7:0] cur;           // Current content at the write address

    // Cells leave the factory erased
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = flash_pkg::ERASED_BYTE;
        end
    end

    // Erase sets ones, programming ANDs zeros in
    always_ff @(posedge sys_clk) begin
        if (arr.wipe_we) begin
            mem[arr.waddr] <= flash_pkg::ERASED_BYTE;   // see [RULE1]
        end else if (arr.prog_we) begin
            mem[arr.waddr] <= mem[arr.waddr] & arr.wdata; // see [RULE1]
        end
    end

    assign cur = mem[arr.waddr];
    assign arr.rdata = mem[arr.raddr];
    assign arr.protect_byte = mem[PROT_IDX];

    // A programmed cell holds exactly old AND data one cycle later
    property p_prog_clears_only;
        @(posedge sys_clk) disable iff (sys_rst)
        (arr.prog_we && !arr.wipe_we) |=>
            mem[$past(arr.waddr)] == ($past(cur) & $past(arr.wdata));
    endproperty
    a_prog_clears_only: assert property (p_prog_clears_only) // see [RULE1]
        else $error("programmed cell does not read old AND data");
endmodule

// >>> verilog/flash_program_erase_control.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] Erased bits read one, programmed bits zero
// [RULE2] Pages of 64 bytes, two 32-byte rows
// [RULE3] Array at top, control FE08, protect FF7E
// [RULE4] High voltage only with a select, in sequence
// [RULE5] Bulk bit picks whole array or page
// [RULE6] Erase and program selects never both one
// [RULE7] Erase page is 64 aligned bytes, vectors too
// [RULE8] Page erase: select, protect read, write, wait
// [RULE9] Hold erase, drop select, wait, drop voltage
// [RULE10] Use long erase time above 1000 cycles
// [RULE11] Bulk erase: both selects, read, write, hold
// [RULE12] End bulk erase: clear selects, wait 100 us
// [RULE13] Bulk erase blocked unless protect byte all ones
// [RULE14] Secured monitor: dummy write hits protect byte
// [RULE15] Program row is 32 aligned bytes
// [RULE16] One programming cycle stays in one row
// [RULE17] Only erased bytes may be programmed
// [RULE18] Program select latches address, then timed steps
// [RULE19] Per byte wait, then drop select and voltage
// [RULE20] Gaps between writes stay under byte maximum
// [RULE21] Cumulative row voltage time stays under maximum
// [RULE22] Steps in order; run code from elsewhere
// [RULE23] No high voltage on a protected target
// [RULE24] Protect bits form start address bits 13..6
// [RULE25] Track sequence; ignore out-of-order voltage enable
module flash_program_erase_control (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flash_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic charge_pump_on
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic hv;                        // High voltage enable
        logic bulk;                      // Bulk (whole array) select
        logic erase;                     // Erase select
        logic prog;                      // Program select
        flash_pkg::seq_t seq;            // Sequence position
        logic [13:0] row;                // Latched target address
        logic [13:0] wipe_ptr;           // Next cell to erase
        logic wiping;                    // Erase walk in progress
        logic wipe_all;                  // Walk covers whole array
        logic fail;                      // Row crossed in a program
        logic [7:0] nvs_cnt;             // Cycles since latch write
        logic [7:0] rdata;               // Read data for the access
    } state_t;

    state_t q;                           // Registered state
    state_t d;                           // Next state

    flash_array_if #(.AW(flash_pkg::ARR_AW)) arr ();

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [15:0] cpu_addr;               // CPU byte address
    logic [13:0] idx;                    // Array index of cpu_addr
    logic setup;                         // First APB cycle
    logic access;                        // Completing APB cycle
    logic is_ctrl;
    logic is_status;
    logic is_array;
    logic in_hole;
    logic mapped;
    logic ctrl_wr;
    logic arr_wr;
    logic prot_rd;
    logic prot_hit;                      // Latched target protected
    logic bulk_ok;                       // Protect byte all ones
    logic hv_ok;                         // Raising voltage allowed
    logic nvs_done;                      // Setup time has passed
    logic [7:0] ctrl_byte;
    logic [7:0] status_byte;

    // Register window: the CPU space sits at four bytes per address
    always_comb begin
        cpu_addr = paddr[flash_pkg::APB_AW-1:2];
        idx = cpu_addr[flash_pkg::ARR_AW-1:0];
        setup = psel && !penable;
        access = psel && penable;
        is_ctrl = (cpu_addr == flash_pkg::CTRL_ADDR);     // see [RULE3]
        is_status = (cpu_addr == flash_pkg::STATUS_ADDR);
        // Registers live in a hole inside the array range
        in_hole = (cpu_addr[15:4] == flash_pkg::HOLE_PREFIX);
        is_array = (cpu_addr >= flash_pkg::ARRAY_BASE) && !in_hole;
        mapped = is_ctrl || is_status || is_array;
        ctrl_wr = access && pwrite && is_ctrl;
        arr_wr = access && pwrite && is_array;
        prot_rd = access && !pwrite &&
                  (cpu_addr == flash_pkg::PROTECT_ADDR);  // see [RULE3]
    end

    // Protection is judged on the address latched by the dummy write
    flash_protect_check u_protect (
        .protect_start_bits(arr.protect_byte),
        .target(q.row),
        .hit(prot_hit),
        .bulk_ok(bulk_ok)
    );

    flash_cell_array #(.DEPTH(flash_pkg::DEPTH)) u_cells (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .arr(arr.cells)
    );

    // ------------------------------------------------------------
    // Readable views
    // ------------------------------------------------------------
    // Control bits, unused bits read zero
    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[flash_pkg::HV_BIT] = q.hv;
        ctrl_byte[flash_pkg::BULK_BIT] = q.bulk;
        ctrl_byte[flash_pkg::ERASE_BIT] = q.erase;
        ctrl_byte[flash_pkg::PROG_BIT] = q.prog;
        status_byte = 8'h00;
        status_byte[flash_pkg::ST_WIPING] = q.wiping;
        status_byte[flash_pkg::ST_FAIL] = q.fail;
        status_byte[flash_pkg::ST_HV] = (q.seq == flash_pkg::S_HV_ON);
        status_byte[flash_pkg::ST_LATCHED] =
            (q.seq == flash_pkg::S_LATCHED);
    end

    // The setup wait is counted by hardware as well, so a voltage
    // enable written too soon after the latch write is refused
    assign nvs_done = (q.nvs_cnt == flash_pkg::NVS_CYC);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        arr.prog_we = 1'b0;
        arr.wipe_we = 1'b0;
        arr.waddr = idx;
        arr.wdata = pwdata[7:0];
        arr.raddr = idx;
        hv_ok = 1'b0;

        // Read data is fetched in setup and stands through access
        if (setup) begin
            if (is_ctrl) begin
                d.rdata = ctrl_byte;
            end else if (is_status) begin
                d.rdata = status_byte;
            end else if (is_array) begin
                d.rdata = arr.rdata;                      // see [RULE1]
            end else begin
                d.rdata = 8'h00;
            end
        end

        // Setup timer runs only between latch write and voltage
        if (q.seq == flash_pkg::S_LATCHED && !nvs_done) begin
            d.nvs_cnt = q.nvs_cnt + 8'h01;
        end

        if (ctrl_wr) begin
            // Both selects at one is refused; the old pair stands
            if (!(pwdata[flash_pkg::ERASE_BIT] &&
                  pwdata[flash_pkg::PROG_BIT])) begin   // see [RULE6]
                d.erase = pwdata[flash_pkg::ERASE_BIT];
                d.prog = pwdata[flash_pkg::PROG_BIT];
            end
            d.bulk = pwdata[flash_pkg::BULK_BIT];         // see [RULE5]

            // Voltage may rise only from the latched step, after the
            // setup time, with a select, on an open target
            hv_ok = (q.seq == flash_pkg::S_LATCHED) && nvs_done &&
                    (d.erase || d.prog);                  // see [RULE4]
            if (d.erase && d.bulk) begin
                hv_ok = hv_ok && bulk_ok;                 // see [RULE13]
            end else begin
                hv_ok = hv_ok && !prot_hit;               // see [RULE23]
            end

            if (!pwdata[flash_pkg::HV_BIT]) begin
                // Dropping voltage always works and ends the cycle
                d.hv = 1'b0;
                d.wiping = 1'b0;
                if (!d.erase && !d.prog) begin
                    d.seq = flash_pkg::S_IDLE;
                end else if (q.hv || q.seq == flash_pkg::S_IDLE) begin
                    d.seq = flash_pkg::S_SELECTED;
                end
            end else if (!q.hv && hv_ok) begin
                d.hv = 1'b1;                              // see [RULE25]
                d.seq = flash_pkg::S_HV_ON;
                if (d.erase) begin
                    // Bulk walks all cells, page walks one page
                    d.wiping = 1'b1;
                    d.wipe_all = d.bulk;                  // see [RULE5]
                    d.wipe_ptr = d.bulk ? '0 :
                        {q.row[13:flash_pkg::PAGE_LSB], // see [RULE2]
                         flash_pkg::PAGE_LAST ^ flash_pkg::PAGE_LAST};
                end
            end else if (!q.hv) begin
                // Out-of-order enable: voltage stays off
                d.hv = 1'b0;                              // see [RULE25]
                if (!d.erase && !d.prog) begin
                    d.seq = flash_pkg::S_IDLE;
                end else if (q.seq == flash_pkg::S_IDLE) begin
                    d.seq = flash_pkg::S_SELECTED;
                end
            end

            // A fresh cycle starts with a clean row-cross flag
            if (q.seq == flash_pkg::S_IDLE &&
                d.seq == flash_pkg::S_SELECTED) begin
                d.fail = 1'b0;
            end
        end

        // Protect byte read arms the latch step
        if (prot_rd && q.seq == flash_pkg::S_SELECTED) begin
            d.seq = flash_pkg::S_PROT_READ;               // see [RULE25]
        end

        if (arr_wr) begin
            if (q.seq == flash_pkg::S_PROT_READ) begin
                // Dummy write latches the target page or row
                d.row = idx;                              // see [RULE18]
                d.seq = flash_pkg::S_LATCHED;
                d.nvs_cnt = 8'h00;
            end else if (q.seq == flash_pkg::S_HV_ON && q.prog) begin
                // Only addresses in the latched row are programmed
                if (idx[13:flash_pkg::ROW_LSB] ==
                    q.row[13:flash_pkg::ROW_LSB]) begin   // see [RULE15]
                    arr.prog_we = 1'b1;                   // see [RULE16]
                end else begin
                    d.fail = 1'b1;                        // see [RULE16]
                end
            end
        end

        // Erase walk, one cell a cycle, only while voltage is up;
        // it outruns the minimum hold time for both scopes
        if (q.wiping && q.hv) begin
            arr.wipe_we = 1'b1;
            arr.waddr = q.wipe_ptr;
            d.wipe_ptr = q.wipe_ptr + 14'h0001;
            if (q.wipe_all ? (q.wipe_ptr == flash_pkg::ARR_LAST) :
                (q.wipe_ptr[flash_pkg::PAGE_LSB-1:0] ==
                 flash_pkg::PAGE_LAST)) begin             // see [RULE7]
                d.wiping = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset drops voltage and all selects
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = {24'h000000, q.rdata};
    assign charge_pump_on = q.hv;                         // see [RULE4]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_prot_read_done;
        q.seq == flash_pkg::S_PROT_READ;
    endsequence

    sequence s_latch_write;
        s_prot_read_done ##0 arr_wr;
    endsequence

    property p_interlock;
        !(q.erase && q.prog);
    endproperty
    a_interlock: assert property (p_interlock) // see [RULE6]
        else $error("erase and program selects both set");

    property p_hv_in_order;
        $rose(q.hv) |-> $past(q.seq) == flash_pkg::S_LATCHED &&
                        (q.erase || q.prog);
    endproperty
    a_hv_in_order: assert property (p_hv_in_order) // see [RULE4]
        else $error("voltage raised outside the latched step");

    property p_bulk_blocked;
        ($rose(q.hv) && q.erase && q.bulk) |->
            $past(arr.protect_byte) == flash_pkg::ERASED_BYTE;
    endproperty
    a_bulk_blocked: assert property (p_bulk_blocked) // see [RULE13]
        else $error("bulk erase started with protection set");

    property p_protected_target;
        ($rose(q.hv) && !(q.erase && q.bulk)) |-> !$past(prot_hit);
    endproperty
    a_protected_target: assert property (p_protected_target) // see [RULE23]
        else $error("voltage raised on a protected target");

    property p_ignore_early_hv;
        (ctrl_wr && pwdata[flash_pkg::HV_BIT] && !q.hv &&
         q.seq != flash_pkg::S_LATCHED) |=> !q.hv [*2];
    endproperty
    a_ignore_early_hv: assert property (p_ignore_early_hv) // see [RULE25]
        else $error("out-of-order voltage enable accepted");

    property p_latch_row;
        s_latch_write |=> q.seq == flash_pkg::S_LATCHED &&
                          q.row == $past(idx) && q.nvs_cnt == 8'h00;
    endproperty
    a_latch_row: assert property (p_latch_row) // see [RULE18]
        else $error("dummy write did not latch the target");

    property p_setup_time;
        $rose(q.hv) |-> $past(q.nvs_cnt) == flash_pkg::NVS_CYC;
    endproperty
    a_setup_time: assert property (p_setup_time) // see [RULE18]
        else $error("voltage raised before the setup time");

    property p_row_cross;
        (arr_wr && q.seq == flash_pkg::S_HV_ON && q.prog &&
         idx[13:flash_pkg::ROW_LSB] != q.row[13:flash_pkg::ROW_LSB])
            |-> !arr.prog_we ##1 q.fail;
    endproperty
    a_row_cross: assert property (p_row_cross) // see [RULE16]
        else $error("write outside the row was not refused");

    property p_page_scope;
        (q.wiping && !q.wipe_all) |->
            q.wipe_ptr[13:flash_pkg::PAGE_LSB] ==
            q.row[13:flash_pkg::PAGE_LSB];
    endproperty
    a_page_scope: assert property (p_page_scope) // see [RULE7]
        else $error("page erase walked outside its page");

endmodule

// >>> sim/cpu_model.sv
`timescale 1ns/10ps
// CPU core stand-in: APB master plus the flash routines it runs
module cpu_model (
    input wire logic sys_clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [flash_pkg::APB_AW-1:0] paddr,
    output logic [31:0] pwdata
);
    // ------------------------------------------------------------
    // Waits in cycles of 50 ns
    // ------------------------------------------------------------
    localparam int NVS = 200;   // 10 us select to high voltage
    localparam int PGS = 100;   // 5 us high voltage to first byte
    localparam int PROG = 600;  // 30 us per byte
    localparam int NVH = 100;   // 5 us deselect to high voltage off
    localparam int NVHL = 2000; // 100 us after a bulk erase
    localparam int RCV = 20;    // 1 us read recovery
    // Erase holds cut short to keep the run brief; both still
    // outlast the cells' own wipe walk
    localparam int PAGE_HOLD = 100;
    localparam int BULK_HOLD = 16500;
    localparam logic [15:0] CTRL = flash_pkg::CTRL_ADDR;
    logic [7:0] rd_q; // Sink for dummy reads
    logic err_q;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // One transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [15:0] a,
            input logic [7:0] d, output logic [7:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data show the inverse, never a stale copy
        paddr <= ~{a, 2'b00};
        pwdata <= ~{24'h0, d};
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, rd_q, err_q);
    endtask

    // One read; data and error flag as the access ends
    task automatic rd_byte(input logic [15:0] a, output logic [7:0] r,
            output logic e);
        xfer(1'b0, a, 8'h00, r, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Select, protect read, dummy write, setup wait, voltage on
    task automatic arm(input logic [7:0] sel, input logic [15:0] a);
        wr(CTRL, sel);
        rd_byte(flash_pkg::PROTECT_ADDR, rd_q, err_q);
        wr(a, 8'h5e);
        idle(NVS);
        wr(CTRL, sel | 8'h08);
        idle(PGS);
    endtask

    // Hold, drop selects, wait, drop voltage, recover
    task automatic disarm(input logic [1:0] kind);
        int hold;
        hold = kind == 2'd2 ? BULK_HOLD : (kind == 2'd1 ? PAGE_HOLD : 0);
        idle(hold);
        wr(CTRL, 8'h08);
        idle(kind == 2'd2 ? NVHL : NVH);
        wr(CTRL, 8'h00);
        idle(RCV);
    endtask

    // One byte onto an erased cell, then the per-byte wait
    task automatic prog_byte(input logic [15:0] a, input logic [7:0] d);
        wr(a, d);
        idle(PROG);
    endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic sys_clk, sys_rst, psel, penable, pwrite;
    logic pready, pslverr, charge_pump_on, e;
    logic [flash_pkg::APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] r;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    localparam logic [15:0] CTRL = flash_pkg::CTRL_ADDR;

    flash_program_erase_control flash_program_erase_control_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .charge_pump_on(charge_pump_on));
    cpu_model cpu_model_i (
        .sys_clk(sys_clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Hang guard: whole run needs about 26000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        cpu_model_i.rd_byte(a, r, e);
        chk(r, exp);
    endtask

    // Let the edge's updates land before looking at the pump
    task automatic pump(input logic exp);
        #1;
        chk({7'h0, charge_pump_on}, {7'h0, exp});
    endtask

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(CTRL, 8'h00);
        pump(1'b0);
        rd(16'hc000, 8'hff);
        // Unmapped hole reads zero and flags an error
        rd(16'hfe00, 8'h00);
        chk({7'h0, e}, 8'h01);
        cpu_model_i.wr(CTRL, 8'h03);
        rd(CTRL, 8'h00);
        cpu_model_i.wr(CTRL, 8'h02);
        cpu_model_i.wr(CTRL, 8'h03);
        rd(CTRL, 8'h02);
        cpu_model_i.wr(CTRL, 8'h06);
        rd(CTRL, 8'h06);
        cpu_model_i.wr(CTRL, 8'h0e);
        pump(1'b0);
        cpu_model_i.wr(CTRL, 8'h00);
        // Program first and last byte of row C000
        cpu_model_i.arm(8'h01, 16'hc000);
        pump(1'b1);
        cpu_model_i.prog_byte(16'hc000, 8'h5a);
        cpu_model_i.prog_byte(16'hc01f, 8'ha5);
        cpu_model_i.disarm(2'd0);
        pump(1'b0);
        rd(16'hc000, 8'h5a);
        rd(16'hc01f, 8'ha5);
        // Protect start FF80, plus a marker in the same row
        cpu_model_i.arm(8'h01, 16'hff60);
        cpu_model_i.prog_byte(16'hff7e, 8'hfe);
        cpu_model_i.prog_byte(16'hff60, 8'h00);
        cpu_model_i.disarm(2'd0);
        rd(16'hff7e, 8'hfe);
        // A byte outside the latched row is not written; fail is raised
        cpu_model_i.arm(8'h01, 16'hc020);
        cpu_model_i.prog_byte(16'hc040, 8'h00);
        rd(16'hfe09, 8'h06);
        cpu_model_i.disarm(2'd0);
        rd(16'hc040, 8'hff);
        // Erase at the exact protect start is refused
        cpu_model_i.arm(8'h02, 16'hff80);
        pump(1'b0);
        cpu_model_i.disarm(2'd0);
        cpu_model_i.arm(8'h06, 16'hc000);
        pump(1'b0);
        cpu_model_i.disarm(2'd0);
        // Page erase wipes its own 64 bytes only
        cpu_model_i.arm(8'h02, 16'hc000);
        pump(1'b1);
        cpu_model_i.disarm(2'd1);
        rd(16'hc01f, 8'hff);
        rd(16'hff60, 8'h00);
        // Page just below the start is open; it holds the protect byte
        cpu_model_i.arm(8'h02, 16'hff40);
        pump(1'b1);
        cpu_model_i.disarm(2'd1);
        rd(16'hff7e, 8'hff);
        cpu_model_i.arm(8'h01, 16'hc0c0);
        cpu_model_i.prog_byte(16'hc0c0, 8'h3c);
        cpu_model_i.disarm(2'd0);
        // Bulk erase with the dummy write aimed at the protect byte
        cpu_model_i.arm(8'h06, 16'hff7e);
        pump(1'b1);
        rd(16'hfe09, 8'h05);
        cpu_model_i.disarm(2'd2);
        rd(16'hc0c0, 8'hff);
        end_of_test();
    end
endmodule
